// >>> logic/fspc_map.vh
// Register map, field positions, reset values and codes of the flash
// sequencer control block. Definitions only; included by fspc_ctrl.v.
`ifndef FSPC_MAP_VH
`define FSPC_MAP_VH

// Register byte addresses on the CPU data bus
`define FSPC_ADDR_FREQ 20'hf00be
`define FSPC_ADDR_MODE 20'hf00c0
`define FSPC_ADDR_CMD 20'hf00c1
`define FSPC_ADDR_ERR 20'hf00c6
`define FSPC_ADDR_END 20'hf00c7

// Reset values
`define FSPC_RST_FREQ 5'h00
`define FSPC_RST_MODE 8'h08
`define FSPC_RST_CMD 8'h00
`define FSPC_RST_STAT 8'h00

// Mode register fields
`define FSPC_MODE_AREA 5
`define FSPC_MODE_DIS 3
`define FSPC_MODE_SPM 1
`define FSPC_MODE_MASK 8'h2a

// Frequency register field
`define FSPC_FREQ_MSB 4

// Command register fields
`define FSPC_CMD_START 7
`define FSPC_CMD_MSB 2

// Status register fields
`define FSPC_END_BIT 6
`define FSPC_SEQ_ERR_BIT 4
`define FSPC_WR_ERR_BIT 1
`define FSPC_ER_ERR_BIT 0

// Command codes
`define FSPC_OP_NONE 3'h0
`define FSPC_OP_WRITE 3'h1
`define FSPC_OP_ERASE 3'h4

// Erase block sizes in bytes, one bit wider than the operands
`define FSPC_BLK_CODE 14'h0400
`define FSPC_BLK_DATA 14'h0200

`endif

// >>> logic/fspc_ctrl.v
// Control and status logic of the flash self-programming sequencer.
// Assumes the CPU bus, the operand registers and the flash array all run
// on clk_sys; operands come from neighbouring registers as plain inputs.
`timescale 1ns/1ps
`default_nettype none
`include "fspc_map.vh"

////////////////////////////////////////////////////////////////////////
module fspc_ctrl (
  // Clock and reset
  input wire clk_sys,
  input wire nrst,
  // CPU byte access
  input wire [19:0] cpu_addr,
  input wire cpu_wr,
  input wire cpu_rd,
  input wire [7:0] cpu_wdata,
  output reg [7:0] cpu_rdata,
  output reg cpu_wait,
  // Operands from the address and write buffer registers
  input wire [12:0] start_addr,
  input wire [12:0] end_addr,
  input wire [31:0] write_data,
  // Flash array side
  output reg flash_req,
  output reg flash_erase,
  output reg flash_area,
  output reg [12:0] flash_addr,
  output reg [31:0] flash_wdata,
  output reg [4:0] frequency_code,
  output reg self_program_mode,
  output reg program_erase_disable,
  input wire flash_done,
  input wire flash_fail
);

////////////////////////////////////////////////////////////////////////
// State encoding
localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_ISSUE = 2'h1;
localparam [1:0] ST_BUSY = 2'h2;
localparam [1:0] ST_DONE = 2'h3;

reg [1:0] state_reg;
reg [7:0] mode_reg;
reg start_reg;
reg [2:0] command_code_reg;
reg sequencer_end_flag_reg;
reg sequencer_error_flag_reg;
reg write_error_flag_reg;
reg erase_error_flag_reg;
reg [12:0] end_addr_reg;

////////////////////////////////////////////////////////////////////////
// Decode
wire wr_freq = cpu_wr && (cpu_addr == `FSPC_ADDR_FREQ);
wire wr_mode = cpu_wr && (cpu_addr == `FSPC_ADDR_MODE);
wire wr_cmd = cpu_wr && (cpu_addr == `FSPC_ADDR_CMD);
wire wr_start = wr_cmd && cpu_wdata[`FSPC_CMD_START];
wire wr_stop = wr_cmd && !cpu_wdata[`FSPC_CMD_START];
wire [2:0] new_code = cpu_wdata[`FSPC_CMD_MSB:0];
// Starts only count from idle with the end flag clear
wire activate = wr_start && (state_reg == ST_IDLE) &&
  !sequencer_end_flag_reg;
wire area_now = mode_reg[`FSPC_MODE_AREA];
wire refused = mode_reg[`FSPC_MODE_DIS] ||
  !mode_reg[`FSPC_MODE_SPM];
wire code_ok = (new_code == `FSPC_OP_WRITE) ||
  (new_code == `FSPC_OP_ERASE);
// Next erase block, checked for overflow and for the end operand
wire [13:0] blk_step = flash_area ? `FSPC_BLK_DATA :
  `FSPC_BLK_CODE;
wire [13:0] next_blk = {1'b0, flash_addr} + blk_step;
wire more_blk = flash_erase && !next_blk[13] &&
  (next_blk[12:0] <= end_addr_reg);
wire finish = (state_reg == ST_BUSY) && flash_done &&
  (flash_fail || !more_blk);

////////////////////////////////////////////////////////////////////////
// Configuration registers
always @(posedge clk_sys or negedge nrst) begin
  if (!nrst) begin
    mode_reg <= `FSPC_RST_MODE;
    frequency_code <= `FSPC_RST_FREQ;
    self_program_mode <= 1'b0;
    program_erase_disable <= 1'b1;
  end else begin
    if (wr_mode) begin
      mode_reg <= cpu_wdata & `FSPC_MODE_MASK;
      self_program_mode <= cpu_wdata[`FSPC_MODE_SPM];
      program_erase_disable <= cpu_wdata[`FSPC_MODE_DIS];
    end
    if (wr_freq) begin
      frequency_code <= cpu_wdata[`FSPC_FREQ_MSB:0];
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Command register
always @(posedge clk_sys or negedge nrst) begin
  if (!nrst) begin
    start_reg <= 1'b0;
    command_code_reg <= `FSPC_OP_NONE;
  end else if (wr_stop) begin
    start_reg <= 1'b0;
    command_code_reg <= new_code;
  end else if (activate) begin
    start_reg <= 1'b1;
    command_code_reg <= new_code;
  end
end

////////////////////////////////////////////////////////////////////////
// Sequencer
always @(posedge clk_sys or negedge nrst) begin
  if (!nrst) begin
    state_reg <= ST_IDLE;
    cpu_wait <= 1'b0;
    flash_req <= 1'b0;
    flash_erase <= 1'b0;
    flash_area <= 1'b0;
    flash_addr <= 13'h0000;
    flash_wdata <= 32'h00000000;
    end_addr_reg <= 13'h0000;
  end else if (wr_stop) begin
    state_reg <= ST_IDLE;
    cpu_wait <= 1'b0;
    flash_req <= 1'b0;
  end else begin
    case (state_reg)
      ST_IDLE: begin
        if (activate) begin
          // Area, write data and end operand are frozen for the whole command
          flash_area <= area_now;
          flash_addr <= start_addr;
          flash_wdata <= write_data;
          end_addr_reg <= end_addr;
          flash_erase <= (new_code == `FSPC_OP_ERASE);
          if (refused || !code_ok) begin
            state_reg <= ST_DONE;
          end else begin
            state_reg <= ST_ISSUE;
            cpu_wait <= 1'b1;
          end
        end
      end
      ST_ISSUE: begin
        flash_req <= 1'b1;
        state_reg <= ST_BUSY;
      end
      ST_BUSY: begin
        flash_req <= 1'b0;
        if (flash_done) begin
          if (finish) begin
            state_reg <= ST_DONE;
            cpu_wait <= 1'b0;
          end else begin
            flash_addr <= next_blk[12:0];
            state_reg <= ST_ISSUE;
          end
        end
      end
      ST_DONE: begin
        state_reg <= ST_DONE;
      end
      default: begin
        state_reg <= ST_IDLE;
      end
    endcase
  end
end

////////////////////////////////////////////////////////////////////////
// Status flags
wire set_end = finish || (activate && (refused || !code_ok));
wire fail_now = (finish && flash_fail) ||
  (activate && (refused || !code_ok) && (new_code != `FSPC_OP_NONE));
wire fail_wr = fail_now && (activate ?
  (new_code == `FSPC_OP_WRITE) : !flash_erase);
wire fail_er = fail_now && (activate ?
  (new_code == `FSPC_OP_ERASE) : flash_erase);

always @(posedge clk_sys or negedge nrst) begin
  if (!nrst) begin
    sequencer_end_flag_reg <= 1'b0;
    sequencer_error_flag_reg <= 1'b0;
    write_error_flag_reg <= 1'b0;
    erase_error_flag_reg <= 1'b0;
  end else begin
    // Set wins over a stop in the same cycle
    if (set_end) begin
      sequencer_end_flag_reg <= 1'b1;
    end else if (wr_stop) begin
      sequencer_end_flag_reg <= 1'b0;
    end
    if (fail_now) begin
      sequencer_error_flag_reg <= 1'b1;
    end else if (activate) begin
      sequencer_error_flag_reg <= 1'b0;
    end
    if (fail_wr) begin
      write_error_flag_reg <= 1'b1;
    end else if (activate) begin
      write_error_flag_reg <= 1'b0;
    end
    if (fail_er) begin
      erase_error_flag_reg <= 1'b1;
    end else if (activate) begin
      erase_error_flag_reg <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Read data, registered; unmapped addresses read zero
reg [7:0] rd_next;
always @* begin
  rd_next = 8'h00;
  case (cpu_addr)
    `FSPC_ADDR_FREQ: rd_next = {3'h0, frequency_code};
    `FSPC_ADDR_MODE: rd_next = mode_reg;
    `FSPC_ADDR_CMD: rd_next = {start_reg, 4'h0, command_code_reg};
    `FSPC_ADDR_ERR: begin
      rd_next[`FSPC_SEQ_ERR_BIT] = sequencer_error_flag_reg;
      rd_next[`FSPC_WR_ERR_BIT] = write_error_flag_reg;
      rd_next[`FSPC_ER_ERR_BIT] = erase_error_flag_reg;
    end
    `FSPC_ADDR_END: rd_next[`FSPC_END_BIT] = sequencer_end_flag_reg;
    default: rd_next = 8'h00;
  endcase
end

always @(posedge clk_sys or negedge nrst) begin
  if (!nrst) begin
    cpu_rdata <= `FSPC_RST_STAT;
  end else if (cpu_rd) begin
    cpu_rdata <= rd_next;
  end
end

endmodule // fspc_ctrl
`default_nettype wire

// >>> dv/fspc_checker.sv
// Port checks of the flash sequencer control block.
// Assumes a bind into fspc_ctrl; one clock.
`timescale 1ns/1ps
`default_nettype none
module fspc_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Watched ports
  input wire logic cpu_wait,
  input wire logic flash_req,
  input wire logic flash_done,
  input wire logic flash_area,
  input wire logic flash_erase,
  input wire logic self_program_mode,
  input wire logic program_erase_disable
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  AST_RST_MODE: assert property ($rose(nrst) |-> program_erase_disable && !self_program_mode)
    else $error("mode bits wrong after reset");
  AST_DIS_REQ: assert property (program_erase_disable |-> !flash_req)
    else $error("request while disabled");
  AST_SPM_REQ: assert property (!self_program_mode |-> !flash_req)
    else $error("request in read mode");
  AST_START_REQ: assert property ($rose(cpu_wait) |=> flash_req)
    else $error("no request after start");
  AST_REQ_PULSE: assert property (flash_req |=> !flash_req)
    else $error("request longer than a cycle");
  AST_REQ_WAIT: assert property (flash_req |-> cpu_wait)
    else $error("request without cpu wait");
  AST_WAIT_END: assert property ($fell(cpu_wait) |-> $past(flash_done))
    else $error("wait released early");
  AST_HOLD: assert property (cpu_wait && $past(cpu_wait, 2) |-> $stable(flash_area) && $stable(flash_erase))
    else $error("command changed while running");
endmodule // fspc_checker
`default_nettype wire

// >>> dv/fspc_flash_model.sv
// Behavioural flash array answering requests.
// Assumes one request outstanding at a time.
`timescale 1ns/1ps
`default_nettype none
module fspc_flash_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Request and answer style
  input wire logic flash_req,
  input wire logic slow,
  input wire logic fail_en,
  // Answer
  output logic flash_done,
  output logic flash_fail
);
  logic [3:0] cnt_reg;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 4'h0;
      flash_done <= 1'b0;
      flash_fail <= 1'b0;
    end else begin
      flash_done <= cnt_reg == 4'h1;
      // Fail means nothing without done, so it toggles there
      flash_fail <= (cnt_reg == 4'h1) ? fail_en : ~flash_fail;
      cnt_reg <= flash_req ? (slow ? 4'h9 : 4'h2) : cnt_reg - {3'h0, cnt_reg != 4'h0};
    end
  end
endmodule // fspc_flash_model
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench of the flash sequencer control block.
// Assumes the design, flash model and checker compile first.
`timescale 1ns/1ps
`default_nettype none
`include "fspc_map.vh"
module tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [19:0] cpu_addr = 20'h0;
  logic [7:0] cpu_wdata = 8'h0;
  logic [12:0] start_addr = 13'h0;
  logic [12:0] end_addr = 13'h0;
  logic [31:0] write_data = 32'h0;
  logic cpu_wr = 1'b0, cpu_rd = 1'b0, fail_en = 1'b0, slow = 1'b0, rd_seen = 1'b0;
  logic [7:0] cpu_rdata;
  logic cpu_wait, flash_req, flash_erase, flash_area, flash_done, flash_fail;
  logic [12:0] flash_addr;
  logic [31:0] flash_wdata;
  logic [4:0] frequency_code;
  logic self_program_mode, program_erase_disable;
  logic [31:0] seed = 32'hf3baddf4;
  logic [7:0] rq[$];
  logic [46:0] fq[$];
  int error_cnt = 0, comparisons = 0, cyc = 0, a, k;
  fspc_ctrl DUT (.clk_sys, .nrst, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata,
    .cpu_wait, .start_addr, .end_addr, .write_data, .flash_req, .flash_erase, .flash_area,
    .flash_addr, .flash_wdata, .frequency_code, .self_program_mode,
    .program_erase_disable, .flash_done, .flash_fail);
  fspc_flash_model u_flash (.clk_sys, .nrst, .flash_req, .slow, .fail_en, .flash_done,
    .flash_fail);
  always #12.5 clk_sys = ~clk_sys;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [46:0] s, input logic [46:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask
  task complete_run;
    if (error_cnt == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One byte access; a read notes its expected data
  task automatic acc(input logic w, input logic [19:0] ad, input logic [7:0] d);
    if (!w)
      rq.push_back(d);
    cpu_addr <= ad;
    cpu_wdata <= d;
    cpu_wr <= w;
    cpu_rd <= !w;
    @(posedge clk_sys);
    cpu_wr <= 1'b0;
    cpu_rd <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic run_op(input logic [2:0] op, input logic ar, input logic fl);
    logic [12:0] sa, ea;
    logic [13:0] ad;
    int n;
    seed = lfsr(seed);
    sa = (op == 3'h1) ? seed[12:0] & (ar ? 13'h03fc : 13'h1ffc) : {3'h0, ar, 9'h0};
    ea = sa + (ar ? 13'h0200 : 13'h0400) * (fl ? 13'h1 : 13'h2) - 13'h4;
    start_addr <= sa;
    end_addr <= ea;
    write_data <= seed;
    fail_en <= fl;
    slow <= seed[31];
    if (op == 3'h1)
      fq.push_back({ar, 1'b0, sa, seed});
    for (ad = {1'b0, sa}; op == 3'h4 && ad <= {1'b0, ea}; ad += (ar ? 14'h200 : 14'h400))
      fq.push_back({ar, 1'b1, ad[12:0], 32'h0});
    acc(1'b1, `FSPC_ADDR_MODE, {2'b00, ar, 5'b00010});
    check({45'h0, program_erase_disable, self_program_mode}, 47'h1);
    acc(1'b1, `FSPC_ADDR_CMD, {5'h10, op});
    n = 0;
    repeat (2) @(posedge clk_sys);
    while (cpu_wait && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    acc(1'b0, `FSPC_ADDR_END, 8'h40);
    acc(1'b1, `FSPC_ADDR_CMD, 8'h00);
    acc(1'b0, `FSPC_ADDR_END, 8'h00);
    acc(1'b0, `FSPC_ADDR_ERR, fl ? ((op == 3'h1) ? 8'h12 : 8'h11) : 8'h00);
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run;
    end
    rd_seen <= cpu_rd;
    if (rd_seen)
      check({39'h0, cpu_rdata}, rq.size() ? {39'h0, rq.pop_front()} : 'x);
    if (flash_req)
      check({flash_area, flash_erase, flash_addr, flash_wdata & {32{~flash_erase}}},
        fq.size() ? fq.pop_front() : 'x);
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    check({45'h0, program_erase_disable, self_program_mode}, 47'h2);
    acc(1'b0, `FSPC_ADDR_MODE, 8'h08);
    acc(1'b0, `FSPC_ADDR_FREQ, 8'h00);
    acc(1'b0, `FSPC_ADDR_CMD, 8'h00);
    acc(1'b1, `FSPC_ADDR_ERR, 8'hff);
    acc(1'b1, `FSPC_ADDR_END, 8'hff);
    acc(1'b0, `FSPC_ADDR_ERR, 8'h00);
    acc(1'b0, `FSPC_ADDR_END, 8'h00);
    acc(1'b0, 20'hf00c2, 8'h00);
    seed = lfsr(seed);
    acc(1'b1, `FSPC_ADDR_FREQ, seed[7:0]);
    acc(1'b0, `FSPC_ADDR_FREQ, seed[7:0] & 8'h1f);
    check({42'h0, frequency_code}, {42'h0, seed[4:0]});
    acc(1'b1, `FSPC_ADDR_MODE, seed[15:8]);
    acc(1'b0, `FSPC_ADDR_MODE, seed[15:8] & 8'h2a);
    check({45'h0, program_erase_disable, self_program_mode}, {45'h0, seed[11], seed[9]});
    acc(1'b1, `FSPC_ADDR_MODE, 8'h0a);
    acc(1'b1, `FSPC_ADDR_CMD, 8'h81);
    acc(1'b0, `FSPC_ADDR_END, 8'h40);
    acc(1'b0, `FSPC_ADDR_ERR, 8'h12);
    acc(1'b1, `FSPC_ADDR_CMD, 8'h00);
    acc(1'b0, `FSPC_ADDR_END, 8'h00);
    for (a = 0; a < 2; a++)
      for (k = 0; k < 6; k++)
        run_op((k % 3 == 0) ? 3'h0 : (k % 3 == 1) ? 3'h1 : 3'h4, a[0], k > 3);
    repeat (4) @(posedge clk_sys);
    check(47'(fq.size()), 47'h0);
    complete_run;
  end
endmodule // tb
bind fspc_ctrl fspc_checker u_chk (.clk_sys(clk_sys), .nrst(nrst), .cpu_wait(cpu_wait),
  .flash_req(flash_req), .flash_done(flash_done), .flash_area(flash_area),
  .flash_erase(flash_erase), .self_program_mode(self_program_mode),
  .program_erase_disable(program_erase_disable));
`default_nettype wire
